/* File: include/spl_map.svh */
// Constants of the serial programming link: codes, frame layout, sizes
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH

// Command codes seen in byte 1 and byte 2 of a frame
`define SPL_CMD_ENABLE    8'hAC
`define SPL_ENABLE_ECHO   8'h53
`define SPL_CMD_ERASE     8'hE0

// Frame layout: four bytes, counted from zero
`define SPL_BYTE_CMD      2'h0
`define SPL_BYTE_ADDR_HI  2'h1
`define SPL_BYTE_ADDR_LO  2'h2
`define SPL_BYTE_DATA     2'h3
`define SPL_BIT_LAST      3'h7

// Frame buffer between the link and the programming engine
`define SPL_FIFO_WIDTH    32
`define SPL_FIFO_DEPTH    32

// Reset values
`define SPL_BYTE_RESET    8'h00
`define SPL_FRAME_RESET   32'h0000_0000

`endif

/* File: include/spl_pkg.sv */
// Types shared by the serial programming link files
package spl_pkg;

    // One whole programming command, first byte in the top bits
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] addrHi;
        logic [7:0] addrLo;
        logic [7:0] data;
    } spl_frame_s;

    // Erase bookkeeping on the system side
    typedef enum logic [0:0] {
        SPL_ERASE_IDLE = 1'b0,
        SPL_ERASE_BUSY = 1'b1
    } spl_erase_e;

endpackage

/* File: hdl/spl_fifo.sv */
// Frame FIFO with registered read data, valid and ready on both sides
module spl_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
    logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
    logic [AW:0]      count_r, count_nxt;
    logic [WIDTH-1:0] outData_r, outData_nxt;
    logic             outValid_r, outValid_nxt;
    logic             doWrite;
    logic             doRead;

    // Full when storage holds DEPTH words; the output register is extra
    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outData  = outData_r;
    assign outValid = outValid_r;
    assign doWrite  = inValid && inReady;
    assign doRead   = (count_r != '0) && (!outValid_r || outReady);

    // Pointer, count and output stage
    always_comb begin
        wrPtr_nxt    = doWrite ? wrPtr_r + 1'b1 : wrPtr_r;
        rdPtr_nxt    = doRead ? rdPtr_r + 1'b1 : rdPtr_r;
        count_nxt    = count_r + (AW+1)'(doWrite) - (AW+1)'(doRead);
        outData_nxt  = doRead ? mem[rdPtr_r] : outData_r;
        outValid_nxt = doRead ? 1'b1 : (outReady ? 1'b0 : outValid_r);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPtr_r    <= '0;
            rdPtr_r    <= '0;
            count_r    <= '0;
            outData_r  <= '0;
            outValid_r <= 1'b0;
        end else begin
            wrPtr_r    <= wrPtr_nxt;
            rdPtr_r    <= rdPtr_nxt;
            count_r    <= count_nxt;
            outData_r  <= outData_nxt;
            outValid_r <= outValid_nxt;
        end
    end

    // Storage needs no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_r] <= inData;
        end
    end
endmodule

/* File: hdl/serial_program_link.sv */
// Serial programming link of the target: slave shifter, mode and erase control
//
// Functional notes
// - Each serial clock pulse shifts one bit in on the data-in line.
// - Each same pulse shifts one bit out on the data-out line.
// - Programming mode exists only while the target reset pin is low.
// - Reset pulse after a chip erase ends the erase cycle.
// - While reset is low, general I/O are inputs without pull-ups.
// - Every command is four bytes: code, two address bytes, data byte.
// - Both data lines carry the most significant bit first.
// - Enable command's second byte echoes during third; else reset pulse, retry. Here misoOe is low through the enable frame; the echo is on misoOut only.
`include "spl_map.svh"

module serial_program_link (
    input  wire logic               sys_clk,
    input  wire logic               reset,
    input  wire logic               progRstN,
    input  wire logic               sck,
    input  wire logic               mosi,
    output logic                    misoOut,
    output logic                    misoOe,
    output spl_pkg::spl_frame_s     frameOut,
    output logic                    frameValid,
    input  wire logic               frameReady,
    input  wire logic [7:0]         rdData,
    input  wire logic               rdValid,
    output logic                    progMode,
    output logic                    ioInputOnly,
    output logic                    pullUpDisable,
    output logic                    eraseActive,
    output logic                    eraseDone,
    output logic                    frameOverflow
);
    // ---------------- Link domain, clocked by the programmer ----------------
    logic [2:0]          bitCnt_r, bitCnt_nxt;
    logic [1:0]          byteCnt_r, byteCnt_nxt;
    logic [7:0]          rxShift_r, rxShift_nxt;
    logic [7:0]          cmdByte_r, cmdByte_nxt;
    logic [7:0]          addrHi_r, addrHi_nxt;
    logic [7:0]          addrLo_r, addrLo_nxt;
    logic [7:0]          txByte_r, txByte_nxt;
    logic                enabled_r, enabled_nxt;
    spl_pkg::spl_frame_s frameHold_r, frameHold_nxt;
    logic                frameTgl_r, frameTgl_nxt;
    logic                rdAck_r, rdAck_nxt;
    logic                rdTgl_r, rdTgl_nxt;
    logic [7:0]          rdByte_r, rdByte_nxt;
    logic                rdLnk1_r;
    logic                rdLnk2_r;
    logic [7:0]          byteIn;
    logic                misoOut_r;
    logic                misoOe_r;

    // Incoming bit joins the shifter from the bottom, so MSB arrives first
    assign byteIn = {rxShift_r[6:0], mosi};

    // Bit and byte framing, enable detection, echo selection
    always_comb begin
        bitCnt_nxt    = bitCnt_r + 3'h1;
        byteCnt_nxt   = byteCnt_r;
        rxShift_nxt   = byteIn;
        cmdByte_nxt   = cmdByte_r;
        addrHi_nxt    = addrHi_r;
        addrLo_nxt    = addrLo_r;
        txByte_nxt    = txByte_r;
        enabled_nxt   = enabled_r;
        frameHold_nxt = frameHold_r;
        frameTgl_nxt  = frameTgl_r;
        rdAck_nxt     = rdAck_r;
        if (bitCnt_r == `SPL_BIT_LAST) begin
            byteCnt_nxt = byteCnt_r + 2'h1;
            // Reply to the next byte is the byte just heard
            txByte_nxt  = byteIn;
            case (byteCnt_r)
                `SPL_BYTE_CMD: begin
                    cmdByte_nxt = byteIn;
                end
                `SPL_BYTE_ADDR_HI: begin
                    addrHi_nxt = byteIn;
                end
                `SPL_BYTE_ADDR_LO: begin
                    addrLo_nxt = byteIn;
                    // Read answers replace the echo in the data byte
                    if (enabled_r && (rdLnk2_r != rdAck_r)) begin
                        // Captured byte is still once its toggle has crossed
                        txByte_nxt = rdByte_r;
                        rdAck_nxt  = rdLnk2_r;
                    end
                end
                `SPL_BYTE_DATA: begin
                    if (!enabled_r) begin
                        // Only a whole enable command opens the session
                        enabled_nxt = (cmdByte_r == `SPL_CMD_ENABLE) &&
                                      (addrHi_r == `SPL_ENABLE_ECHO);
                    end else begin
                        frameHold_nxt = '{cmd: cmdByte_r, addrHi: addrHi_r,
                                          addrLo: addrLo_r, data: byteIn};
                        frameTgl_nxt  = ~frameTgl_r;
                    end
                end
                default: begin
                    cmdByte_nxt = cmdByte_r;
                end
            endcase
        end
    end

    // Link state is cleared by the reset pin going inactive, since the
    // serial clock may stop at any time outside a session
    always_ff @(posedge sck or posedge progRstN) begin
        if (progRstN) begin
            bitCnt_r    <= 3'h0;
            byteCnt_r   <= 2'h0;
            rxShift_r   <= `SPL_BYTE_RESET;
            cmdByte_r   <= `SPL_BYTE_RESET;
            addrHi_r    <= `SPL_BYTE_RESET;
            addrLo_r    <= `SPL_BYTE_RESET;
            txByte_r    <= `SPL_BYTE_RESET;
            enabled_r   <= 1'b0;
            frameHold_r <= `SPL_FRAME_RESET;
            frameTgl_r  <= 1'b0;
            rdAck_r     <= 1'b0;
            rdLnk1_r    <= 1'b0;
            rdLnk2_r    <= 1'b0;
            misoOe_r    <= 1'b0;
        end else begin
            bitCnt_r    <= bitCnt_nxt;
            byteCnt_r   <= byteCnt_nxt;
            rxShift_r   <= rxShift_nxt;
            cmdByte_r   <= cmdByte_nxt;
            addrHi_r    <= addrHi_nxt;
            addrLo_r    <= addrLo_nxt;
            txByte_r    <= txByte_nxt;
            enabled_r   <= enabled_nxt;
            frameHold_r <= frameHold_nxt;
            frameTgl_r  <= frameTgl_nxt;
            rdAck_r     <= rdAck_nxt;
            rdLnk1_r    <= rdTgl_r;
            rdLnk2_r    <= rdLnk1_r;
            misoOe_r    <= enabled_nxt;
        end
    end

    // Outgoing bit changes on the falling edge, ready for the next rise
    always_ff @(negedge sck or posedge progRstN) begin
        if (progRstN) begin
            misoOut_r <= 1'b0;
        end else begin
            misoOut_r <= txByte_r[3'h7 - bitCnt_r];
        end
    end

    assign misoOut = misoOut_r;
    assign misoOe  = misoOe_r;

    // ---------------- System domain ----------------
    logic                rstS1_r, rstS2_r, rstS3_r;
    logic                enS1_r, enS2_r;
    logic                tglS1_r, tglS2_r, tglS3_r, tglSeen_r;
    logic                tglSeen_nxt;
    logic                pend_r, pend_nxt;
    spl_pkg::spl_frame_s pendFrame_r, pendFrame_nxt;
    logic                ovf_r, ovf_nxt;
    spl_pkg::spl_erase_e eraseSt_r, eraseSt_nxt;
    logic                eraseDone_r, eraseDone_nxt;
    logic                progMode_r;
    logic                ioIn_r;
    logic                fifoReady;
    logic                sessionOn;
    logic                newFrame;
    logic                resetPulse;

    // Reset pin is low-active; high on the second stage means no session
    assign sessionOn  = !rstS2_r;
    // Toggle takes one extra stage so it never lands before the pin level
    assign newFrame   = sessionOn && (tglS3_r != tglSeen_r);
    assign resetPulse = rstS2_r && !rstS3_r;

    // Frame hand-off into the FIFO, read byte capture, erase tracking
    always_comb begin
        tglSeen_nxt   = sessionOn ? tglS3_r : 1'b0;
        rdTgl_nxt     = rdTgl_r;
        rdByte_nxt    = rdByte_r;
        pend_nxt      = pend_r;
        pendFrame_nxt = pendFrame_r;
        ovf_nxt       = ovf_r;
        eraseSt_nxt   = eraseSt_r;
        eraseDone_nxt = 1'b0;
        if (pend_r && fifoReady) begin
            pend_nxt = 1'b0;
        end
        if (newFrame) begin
            // A frame still waiting when the next arrives is lost
            ovf_nxt       = ovf_r || (pend_r && !fifoReady);
            pend_nxt      = 1'b1;
            pendFrame_nxt = frameHold_r;
        end
        if (!sessionOn) begin
            rdTgl_nxt = 1'b0;
        end else if (rdValid) begin
            rdByte_nxt = rdData;
            rdTgl_nxt  = ~rdTgl_r;
        end
        case (eraseSt_r)
            spl_pkg::SPL_ERASE_IDLE: begin
                if (newFrame && (frameHold_r.cmd == `SPL_CMD_ERASE)) begin
                    eraseSt_nxt = spl_pkg::SPL_ERASE_BUSY;
                end
            end
            spl_pkg::SPL_ERASE_BUSY: begin
                if (resetPulse) begin
                    eraseSt_nxt   = spl_pkg::SPL_ERASE_IDLE;
                    eraseDone_nxt = 1'b1;
                end
            end
            default: begin
                eraseSt_nxt = spl_pkg::SPL_ERASE_IDLE;
            end
        endcase
    end

    // Synchronisers first stage only feeds the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rstS1_r     <= 1'b1;
            rstS2_r     <= 1'b1;
            rstS3_r     <= 1'b1;
            enS1_r      <= 1'b0;
            enS2_r      <= 1'b0;
            tglS1_r     <= 1'b0;
            tglS2_r     <= 1'b0;
            tglS3_r     <= 1'b0;
            tglSeen_r   <= 1'b0;
            rdTgl_r     <= 1'b0;
            rdByte_r    <= `SPL_BYTE_RESET;
            pend_r      <= 1'b0;
            pendFrame_r <= `SPL_FRAME_RESET;
            ovf_r       <= 1'b0;
            eraseSt_r   <= spl_pkg::SPL_ERASE_IDLE;
            eraseDone_r <= 1'b0;
            progMode_r  <= 1'b0;
            ioIn_r      <= 1'b0;
        end else begin
            rstS1_r     <= progRstN;
            rstS2_r     <= rstS1_r;
            rstS3_r     <= rstS2_r;
            enS1_r      <= enabled_r;
            enS2_r      <= enS1_r;
            tglS1_r     <= frameTgl_r;
            tglS2_r     <= tglS1_r;
            tglS3_r     <= tglS2_r;
            tglSeen_r   <= tglSeen_nxt;
            rdTgl_r     <= rdTgl_nxt;
            rdByte_r    <= rdByte_nxt;
            pend_r      <= pend_nxt;
            pendFrame_r <= pendFrame_nxt;
            ovf_r       <= ovf_nxt;
            eraseSt_r   <= eraseSt_nxt;
            eraseDone_r <= eraseDone_nxt;
            progMode_r  <= sessionOn && enS2_r;
            ioIn_r      <= sessionOn;
        end
    end

    // Buffer toward the programming engine; full stalls the hand-off
    spl_fifo #(
        .WIDTH (`SPL_FIFO_WIDTH),
        .DEPTH (`SPL_FIFO_DEPTH)
    ) u_fifo (
        .clk      (sys_clk),
        .reset    (reset),
        .inData   (pendFrame_r),
        .inValid  (pend_r),
        .inReady  (fifoReady),
        .outData  (frameOut),
        .outValid (frameValid),
        .outReady (frameReady)
    );

    assign progMode      = progMode_r;
    assign ioInputOnly   = ioIn_r;
    assign pullUpDisable = ioIn_r;
    assign eraseActive   = (eraseSt_r == spl_pkg::SPL_ERASE_BUSY);
    assign eraseDone     = eraseDone_r;
    assign frameOverflow = ovf_r;
endmodule

/* File: dv/spl_link_sva.sv */
// Concurrent checks on the system-side ports of the programming link
module spl_link_sva (
    input wire logic                sys_clk,
    input wire logic                reset,
    input wire logic                progRstN,
    input wire logic                misoOe,
    input wire spl_pkg::spl_frame_s frameOut,
    input wire logic                frameValid,
    input wire logic                frameReady,
    input wire logic                progMode,
    input wire logic                ioInputOnly,
    input wire logic                pullUpDisable,
    input wire logic                eraseActive,
    input wire logic                eraseDone,
    input wire logic                frameOverflow
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // Pin synchroniser settles a few edges after the pin holds still
    property p_io; $stable(progRstN)[*6] |-> ioInputOnly == !progRstN; endproperty
    a_io: assert property (p_io) else $error("input-only state wrong");
    property p_pud; pullUpDisable == ioInputOnly; endproperty
    a_pud: assert property (p_pud) else $error("pull-up state wrong");
    property p_mode; progRstN[*6] |-> !progMode; endproperty
    a_mode: assert property (p_mode) else $error("mode outside session");
    property p_oe; progRstN |-> !misoOe; endproperty
    a_oe: assert property (p_oe) else $error("data-out driven outside session");
    property p_entry; $rose(progMode) |-> ioInputOnly; endproperty
    a_entry: assert property (p_entry) else $error("mode entered without reset pin");
    // Erase ends only on the reset pin rising, within a few edges
    property p_eend; $rose(progRstN) && eraseActive |-> ##[1:6] eraseDone; endproperty
    a_eend: assert property (p_eend) else $error("erase not ended");
    property p_edone; eraseDone |-> !eraseActive && $past(eraseActive); endproperty
    a_edone: assert property (p_edone) else $error("erase done out of turn");
    property p_epulse; eraseDone |=> !eraseDone; endproperty
    a_epulse: assert property (p_epulse) else $error("erase done too long");
    property p_hold; frameValid && !frameReady |=> frameValid && $stable(frameOut); endproperty
    a_hold: assert property (p_hold) else $error("frame not held");
    property p_ovf; frameOverflow |=> frameOverflow; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag lost");
endmodule

bind serial_program_link spl_link_sva chk (
    .sys_clk(sys_clk), .reset(reset), .progRstN(progRstN), .misoOe(misoOe),
    .frameOut(frameOut), .frameValid(frameValid), .frameReady(frameReady),
    .progMode(progMode), .ioInputOnly(ioInputOnly), .pullUpDisable(pullUpDisable),
    .eraseActive(eraseActive), .eraseDone(eraseDone), .frameOverflow(frameOverflow)
);

/* File: dv/spl_prog_model.sv */
// Behavioural programmer: serial master on the target's link pins
module spl_prog_model (
    output logic      sck,
    output logic      progRstN,
    output logic      mosi,
    input  wire logic misoOut,
    input  wire logic misoOe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] rx;
    logic [31:0] raw;
    wire logic   misoLine;
    // Programmer pull-up holds the line until the target drives it
    assign misoLine = misoOe ? misoOut : 1'b1;
    // Reset pin starts low for a moment so the link flops see it rise
    initial begin
        sck = 1'b0;
        progRstN = 1'b0;
        mosi = 1'b0;
        #1 progRstN = 1'b1;
    end
    // Reset pin owned here; clock stays low while the target settles
    task automatic start();
        progRstN = 1'b0;
        #400;
    endtask
    task automatic stop();
        progRstN = 1'b1;
    endtask
    // One stray pulse, misaligning the target on purpose
    task automatic stray();
        #40 sck = 1'b1;
        #40 sck = 1'b0;
    endtask
    // Whole frame, no gaps, one bit each way per pulse
    task automatic frame(input logic [31:0] f);
        for (int i = 31; i >= 0; i--) begin
            mosi = f[i];
            #40;
            // Reply bit taken just before the rise, as the target set it up
            rx[i] = misoLine;
            raw[i] = misoOut;
            sck = 1'b1;
            #40 sck = 1'b0;
        end
    endtask
endmodule

/* File: dv/tb_top.sv */
// Testbench of the serial programming link with a programmer model
`include "spl_map.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %0h, expected %0h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ENA = {`SPL_CMD_ENABLE, `SPL_ENABLE_ECHO, 16'h0000};
    localparam logic [31:0] F1  = 32'h2001_02AA;
    localparam logic [31:0] F2  = 32'h2803_0455;
    logic                sysClk = 1'b0;
    logic                reset = 1'b1;
    logic                frameReady = 1'b1;
    logic [7:0]          rdData = 8'h00;
    logic                rdValid = 1'b0;
    logic                sck, progRstN, mosi, misoOut, misoOe, frameValid;
    logic                progMode, ioInputOnly, pullUpDisable;
    logic                eraseActive, eraseDone, frameOverflow;
    spl_pkg::spl_frame_s frameOut;
    spl_pkg::spl_frame_s q[$];
    int                  n_fail = 0;
    int                  num_checks = 0;

    always #5 sysClk = ~sysClk;

    spl_prog_model prog (.sck(sck), .progRstN(progRstN), .mosi(mosi),
        .misoOut(misoOut), .misoOe(misoOe));
    serial_program_link uut (
        .sys_clk(sysClk), .reset(reset), .progRstN(progRstN), .sck(sck), .mosi(mosi),
        .misoOut(misoOut), .misoOe(misoOe), .frameOut(frameOut),
        .frameValid(frameValid), .frameReady(frameReady), .rdData(rdData),
        .rdValid(rdValid), .progMode(progMode), .ioInputOnly(ioInputOnly),
        .pullUpDisable(pullUpDisable), .eraseActive(eraseActive),
        .eraseDone(eraseDone), .frameOverflow(frameOverflow));

    // Frames taken by the engine, in order of hand-off
    always @(posedge sysClk) begin
        if (frameValid === 1'b1 && frameReady === 1'b1) begin
            q.push_back(frameOut);
        end
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (20) @(negedge sysClk);
    endtask
    // Bounded wait for hand-offs; a short queue shows up in the compare
    task automatic waitq(input int n);
        for (int i = 0; i < 60 && q.size() < n; i++)
            @(negedge sysClk);
    endtask
    task automatic t_reset();
        `CHK({progMode, frameValid, eraseActive, frameOverflow}, 4'h0)
        reset = 1'b0;
        settle();
        `CHK({ioInputOnly, misoOe}, 2'h0)
        $display("t_reset done");
    endtask
    // Full enable frame while the reset pin is high must be ignored
    task automatic t_nomode();
        prog.frame(ENA);
        settle();
        `CHK({progMode, misoOe, frameValid}, 3'h0)
        $display("t_nomode done");
    endtask
    task automatic t_enable();
        prog.start();
        settle();
        `CHK({ioInputOnly, pullUpDisable}, 2'h3)
        prog.frame(ENA);
        `CHK(prog.raw, {8'h00, `SPL_CMD_ENABLE, `SPL_ENABLE_ECHO, 8'h00})
        settle();
        `CHK({progMode, misoOe}, 2'h3)
        q.delete();
        $display("t_enable done");
    endtask
    // Back-to-back frames: echo of the previous byte, order kept
    task automatic t_data();
        prog.frame(F1);
        `CHK(prog.rx, {8'h00, F1[31:8]})
        prog.frame(F2);
        `CHK(prog.rx, {F1[7:0], F2[31:8]})
        waitq(2);
        `CHK(q[0], F1)
        `CHK(q[1], F2)
        q.delete();
        $display("t_data done");
    endtask
    // Offered byte replaces the echo in byte 4 once, then is spent
    task automatic t_read();
        rdData = 8'h3C;
        rdValid = 1'b1;
        @(negedge sysClk);
        rdValid = 1'b0;
        rdData = 8'h00; // Offered byte must be held inside, not read live
        prog.frame(32'hA000_1000);
        `CHK(prog.rx, 32'h55A0_003C)
        prog.frame(32'hA000_1100);
        `CHK(prog.rx, 32'h00A0_0011)
        waitq(2);
        q.delete();
        $display("t_read done");
    endtask
    // Engine stalls until the buffer refuses, then drains it empty
    task automatic t_fifo();
        frameReady = 1'b0;
        for (int i = 0; i < 35; i++)
            prog.frame({8'h20, 8'h00, 8'(i), 8'h00});
        settle();
        `CHK({frameValid, frameOverflow}, 2'h3)
        frameReady = 1'b1;
        repeat (80) @(negedge sysClk);
        `CHK(q.size() >= 33, 1'b1)
        `CHK(q[0], 32'h2000_0000)
        `CHK(q[32], 32'h2000_2000)
        `CHK(frameValid, 1'b0)
        q.delete();
        $display("t_fifo done");
    endtask
    task automatic t_erase();
        prog.frame({`SPL_CMD_ERASE, 24'h000000});
        settle();
        `CHK(eraseActive, 1'b1)
        prog.stop();
        for (int i = 0; i < 20 && eraseDone !== 1'b1; i++)
            @(negedge sysClk);
        `CHK({eraseDone, eraseActive}, 2'h2)
        settle();
        `CHK({progMode, misoOe}, 2'h0)
        $display("t_erase done");
    endtask
    // Lost alignment refuses entry; a reset pulse and retry recovers
    task automatic t_stray();
        prog.start();
        prog.stray();
        prog.frame(ENA);
        settle();
        `CHK({progMode, misoOe}, 2'h0)
        prog.stop();
        settle();
        prog.start();
        prog.frame(ENA);
        settle();
        `CHK({progMode, misoOe}, 2'h3)
        prog.stop();
        $display("t_stray done");
    endtask

    initial begin
        repeat (5) @(negedge sysClk);
        t_reset();
        t_nomode();
        t_enable();
        t_data();
        t_read();
        t_fifo();
        t_erase();
        t_stray();
        test_done();
    end
    // Whole run needs about 117 us; cut a hang well after that
    initial begin
        #500000;
        n_fail++;
        test_done();
    end
endmodule
